// File: lin_encoder.sv
/*
  turns a signed raw measurement with its lsb exponent into a linear word.
  assumes one clock, asynchronous active-high reset, and a clock enable.
*/
`timescale 1ns/1ps
module lin_encoder
  import tel_pkg::*;
(
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              ce,
  // raw sample
  input  wire logic                              in_valid,
  input  wire logic [tel_pkg::SLOT_W-1:0]        in_slot,
  input  wire logic signed [tel_pkg::WORD_W-1:0] in_value,
  input  wire logic signed [tel_pkg::EXP_W-1:0]  in_exp,
  // encoded word
  output logic                                   out_valid,
  output logic [tel_pkg::SLOT_W-1:0]             out_slot,
  output logic [tel_pkg::WORD_W-1:0]             out_word
);
  import tel_pkg::*;

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [WORD_W-1:0] word;
  } enc_s;

  enc_s r;
  enc_s n;

  // halve until the mantissa fits; precision is traded for range, and an
  // exponent that overflows five bits wraps, so callers keep in_exp small
  function automatic logic [WORD_W-1:0] to_linear(input logic signed [WORD_W-1:0] v,
                                                  input logic signed [EXP_W-1:0] e);
    logic signed [WORD_W-1:0] m;
    logic signed [EXP_W-1:0]  x;
    m = v;
    x = e;
    for (int i = 0; i < int'(WORD_W - MANT_W); i++)
    begin
      if (m > MANT_MAX || m < MANT_MIN)
      begin
        m = m >>> 1;
        x = x + EXP_STEP;
      end
    end
    return {x, m[MANT_W-1:0]};
  endfunction

  always_comb
  begin
    n       = r;
    n.valid = in_valid;
    if (in_valid)
    begin
      n.slot = in_slot;
      n.word = to_linear(in_value, in_exp);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '0;
    else if (ce)
      r <= n;
  end

  assign out_valid = r.valid;
  assign out_slot  = r.slot;
  assign out_word  = r.word;

  a_linear_pack: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && in_valid && in_value <= MANT_MAX && in_value >= MANT_MIN
    |=> out_valid && out_word == {$past(in_exp), $past(in_value[MANT_W-1:0])})
    else $error("small sample not packed as exponent and mantissa");

endmodule // lin_encoder

// File: pmbus_status_telemetry_regs_tb_top.sv
/*
  self-checking bench for the status and telemetry readback block.
  assumes the host model above on the command port; the bench drives all else.
*/
`timescale 1ns/1ps
module pmbus_status_telemetry_regs_tb_top;
  import tel_pkg::*;
  logic              sys_clk, sys_rst, ce, cmd_valid, clear_faults, rd_valid, rd_unsupported;
  logic [7:0]        cmd_code, rd_code;
  logic [15:0]       rd_data, vout_mv, vid_code;
  logic signed [15:0] meas_value;
  logic signed [4:0] meas_exp;
  logic [2:0]        meas_slot;
  logic [3:0]        ev;
  logic              startup_active, meas_valid, vid_valid;
  int                n_errors, n_compared;

  tel_status_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .clear_faults(clear_faults), .rd_valid(rd_valid), .rd_code(rd_code),
    .rd_data(rd_data), .rd_unsupported(rd_unsupported), .power_stage_fault(ev[3]),
    .startup_active(startup_active), .vout_mv(vout_mv), .output_reset_fault(ev[2]),
    .output_floor_fault(ev[1]), .missing_phase_pulse_fault(ev[0]), .meas_valid(meas_valid),
    .meas_slot(meas_slot), .meas_value(meas_value), .meas_exp(meas_exp),
    .vid_valid(vid_valid), .output_voltage_vid_code(vid_code));

  tel_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rd_valid(rd_valid), .rd_code(rd_code), .rd_data(rd_data), .rd_unsupported(rd_unsupported));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic ux);
    logic [15:0] data;
    logic        unsup;
    logic [7:0]  cs;
    int          lat;
    logic        one_shot;
    host.read(code, data, unsup, cs, lat, one_shot);
    if (lat >= 8)
    begin
      n_errors++;
      report_and_stop();
    end
    check("answer data", data, exp);
    check("answer code", {8'h00, cs}, {8'h00, code});
    check("unsupported flag", {15'h0000, unsup}, {15'h0000, ux});
    check("answer latency", 16'(lat), 16'h0002);
    check("answer pulse", {15'h0000, one_shot}, 16'h0001);
  endtask

  // independent normaliser: halve until the mantissa fits, exponent up per halving
  function automatic logic [15:0] enc(input int v, input int e);
    for (int k = 0; k < 5; k++)
      if (v > 1023 || v < -1024)
      begin
        v = v >>> 1;
        e++;
      end
    return {e[4:0], v[10:0]};
  endfunction

  task automatic clear_all;
    @(negedge sys_clk);
    clear_faults = 1'b1;
    @(negedge sys_clk);
    clear_faults = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(CMD_VENDOR_STATUS, 16'h0000, 1'b0);
    rd(CMD_VIN, 16'h0000, 1'b0);
  endtask

  task automatic t_faults;
    logic [7:0] bitv [4] = '{8'h80, 8'h04, 8'h02, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk);
      ev = 4'h8 >> i;
      @(negedge sys_clk);
      ev = 4'h0;
      rd(CMD_VENDOR_STATUS, {8'h00, bitv[i]}, 1'b0);
      rd(CMD_VENDOR_STATUS, {8'h00, bitv[i]}, 1'b0);
      clear_all();
      rd(CMD_VENDOR_STATUS, 16'h0000, 1'b0);
    end
    @(negedge sys_clk);
    ev = 4'hf;
    @(negedge sys_clk);
    ev = 4'h0;
    rd(CMD_VENDOR_STATUS, 16'h0087, 1'b0);
    clear_all();
    // clear and events in one cycle: the events must survive
    @(negedge sys_clk);
    clear_faults = 1'b1;
    ev           = 4'h9;
    @(negedge sys_clk);
    clear_faults = 1'b0;
    ev           = 4'h0;
    rd(CMD_VENDOR_STATUS, 16'h0081, 1'b0);
    clear_all();
  endtask

  // with the enable low neither an event nor a clear may be taken
  task automatic t_freeze;
    @(negedge sys_clk);
    ev = 4'h8;
    @(negedge sys_clk);
    ce           = 1'b0;
    clear_faults = 1'b1;
    ev           = 4'h1;
    @(negedge sys_clk);
    ce           = 1'b1;
    clear_faults = 1'b0;
    ev           = 4'h0;
    rd(CMD_VENDOR_STATUS, 16'h0080, 1'b0);
    clear_all();
  endtask

  task automatic t_prebias;
    logic        st [3] = '{1'b1, 1'b0, 1'b1};
    logic [15:0] mv [3] = '{16'h0abe, 16'h0bb8, 16'h0abf};
    logic [15:0] ex [3] = '{16'h0000, 16'h0000, 16'h0040};
    for (int i = 0; i < 3; i++)
    begin
      @(negedge sys_clk);
      startup_active = st[i];
      vout_mv        = mv[i];
      @(negedge sys_clk);
      startup_active = 1'b0;
      vout_mv        = 16'h0000;
      rd(CMD_VENDOR_STATUS, ex[i], 1'b0);
      clear_all();
    end
  endtask

  task automatic t_linear;
    logic [7:0] code [5] = '{CMD_VIN, CMD_IIN, CMD_VOUT_LINEAR, CMD_IOUT, CMD_TEMP};
    int         val  [5] = '{12000, -1025, 1023, 100, -40};
    int         ex   [5] = '{-10, -3, -9, -2, 0};
    for (int i = 0; i < 5; i++)
    begin
      @(negedge sys_clk);
      meas_valid = 1'b1;
      meas_slot  = 3'(i);
      meas_value = 16'(val[i]);
      meas_exp   = 5'(ex[i]);
      @(negedge sys_clk);
      meas_valid = 1'b0;
      meas_value = ~meas_value;
    end
    for (int i = 0; i < 5; i++)
      rd(code[i], enc(val[i], ex[i]), 1'b0);
  endtask

  task automatic t_vid_and_unknown;
    @(negedge sys_clk);
    vid_valid = 1'b1;
    vid_code  = 16'h9c3a;
    @(negedge sys_clk);
    vid_valid = 1'b0;
    vid_code  = 16'h63c5;
    rd(CMD_VOUT_VID, 16'h9c3a, 1'b0);
    rd(8'h8a, 16'h0000, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    n_errors       = 0;
    n_compared     = 0;
    sys_rst        = 1'b1;
    ce             = 1'b1;
    clear_faults   = 1'b0;
    ev             = 4'h0;
    startup_active = 1'b0;
    vout_mv        = 16'h0000;
    meas_valid     = 1'b0;
    meas_slot      = 3'h0;
    meas_value     = 16'sh0000;
    meas_exp       = 5'sh00;
    vid_valid      = 1'b0;
    vid_code       = 16'h0000;
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_faults();
    t_freeze();
    t_prebias();
    t_linear();
    t_vid_and_unknown();
    report_and_stop();
  end
endmodule // pmbus_status_telemetry_regs_tb_top

// File: tel_host_model.sv
/*
  host side model: issues one readback command at a time and collects the answer.
  assumes the block answers within a few enabled cycles; it drives on the falling edge.
*/
`timescale 1ns/1ps
module tel_host_model
(
  // clock
  input  wire logic                      sys_clk,
  // command
  output logic                           cmd_valid,
  output logic [tel_pkg::CODE_W-1:0]     cmd_code,
  // answer
  input  wire logic                      rd_valid,
  input  wire logic [tel_pkg::CODE_W-1:0] rd_code,
  input  wire logic [tel_pkg::WORD_W-1:0] rd_data,
  input  wire logic                      rd_unsupported
);
  import tel_pkg::*;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
  end

  // lat counts rising edges from command to answer; 8 means no answer came
  task automatic read(input logic [7:0] code, output logic [15:0] data, output logic unsup,
                      output logic [7:0] code_seen, output int lat, output logic one_shot);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // a released code never shows the old value, so stale decoding cannot pass
    cmd_code  = ~code;
    lat       = 1;
    while (rd_valid !== 1'b1 && lat < 8)
    begin
      @(negedge sys_clk);
      lat++;
    end
    data      = rd_data;
    unsup     = rd_unsupported;
    code_seen = rd_code;
    @(negedge sys_clk);
    one_shot  = (rd_valid === 1'b0);
  endtask
endmodule // tel_host_model

// File: tel_mem.sv
/*
  small word store for the linear telemetry words, registered read data.
  assumes one clock, asynchronous active-high reset, and a clock enable.
*/
`timescale 1ns/1ps
module tel_mem
  import tel_pkg::*;
#(
  parameter int unsigned W = WORD_W,
  parameter int unsigned D = SLOTS
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // port
  tel_mem_if.store  mif
);
  import tel_pkg::*;

  typedef struct packed {
    logic [D-1:0][W-1:0] words;
    logic [W-1:0]        rdata;
  } mem_s;

  mem_s r;
  mem_s n;

  always_comb
  begin
    n = r;
    // a write and a read of one slot in one cycle returns the old word
    if (mif.re)
      n.rdata = r.words[mif.raddr];
    if (mif.we)
      n.words[mif.waddr] = mif.wdata;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '0;
    else if (ce)
      r <= n;
  end

  assign mif.rdata = r.rdata;

endmodule // tel_mem

// File: tel_mem_if.sv
/*
  carrier between the readback logic and its word store.
  assumes one clock; the store samples these on its clock edge.
*/
`timescale 1ns/1ps
interface tel_mem_if;
  import tel_pkg::*;
  logic                 we;
  logic [SLOT_W-1:0]    waddr;
  logic [WORD_W-1:0]    wdata;
  logic                 re;
  logic [SLOT_W-1:0]    raddr;
  logic [WORD_W-1:0]    rdata;

  modport user  (output we, output waddr, output wdata, output re, output raddr,
                 input rdata);
  modport store (input we, input waddr, input wdata, input re, input raddr,
                 output rdata);
endinterface

// File: tel_pkg.sv
/*
  constants shared by the status and telemetry readback block:
  command codes, status bit positions, storage slots, widths and thresholds.
  assumes nothing; imported by every design file of the block.
*/
package tel_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned SLOTS  = 8;
  localparam int unsigned EXP_W  = 5;
  localparam int unsigned MANT_W = 11;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [CODE_W-1:0] CMD_VIN           = 8'h88;
  localparam logic [CODE_W-1:0] CMD_IIN           = 8'h89;
  localparam logic [CODE_W-1:0] CMD_VOUT_VID      = 8'h8b;
  localparam logic [CODE_W-1:0] CMD_IOUT          = 8'h8c;
  localparam logic [CODE_W-1:0] CMD_TEMP          = 8'h8d;
  localparam logic [CODE_W-1:0] CMD_VOUT_LINEAR   = 8'hd4;

  // ----------------------------------------------------------------
  // vendor status byte layout
  // ----------------------------------------------------------------
  localparam int unsigned STS_PS_BIT    = 7;
  localparam int unsigned STS_PB_BIT    = 6;
  localparam int unsigned STS_CS_HI     = 5;
  localparam int unsigned STS_CS_LO     = 3;
  localparam int unsigned STS_RST_BIT   = 2;
  localparam int unsigned STS_FLOOR_BIT = 1;
  localparam int unsigned STS_PHASE_BIT = 0;
  localparam logic [7:0]  STS_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // storage slots of linear words
  // ----------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_VIN  = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_IIN  = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_VOUT = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_IOUT = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_TEMP = 3'h4;

  // ----------------------------------------------------------------
  // linear mantissa range and pre-bias threshold
  // ----------------------------------------------------------------
  localparam logic signed [WORD_W-1:0] MANT_MAX   = 16'sh03ff;
  localparam logic signed [WORD_W-1:0] MANT_MIN   = -16'sh0400;
  localparam logic signed [EXP_W-1:0]  EXP_STEP   = 5'sh01;
  localparam logic [WORD_W-1:0]        PREBIAS_MV = 16'h0abe;

endpackage

// File: tel_status_regs.sv
/*
  vendor fault status byte and telemetry readback commands.
  assumes the bus transaction layer presents one command code per request and
  takes the answer two enabled cycles later; fault detectors give one-cycle
  events, the measurement path gives raw samples with their lsb exponent.
*/
`timescale 1ns/1ps
module tel_status_regs
  import tel_pkg::*;
(
  // clock, reset, enable
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              ce,
  // command from the bus layer
  input  wire logic                              cmd_valid,
  input  wire logic [tel_pkg::CODE_W-1:0]        cmd_code,
  input  wire logic                              clear_faults,
  // answer to the bus layer
  output logic                                   rd_valid,
  output logic [tel_pkg::CODE_W-1:0]             rd_code,
  output logic [tel_pkg::WORD_W-1:0]             rd_data,
  output logic                                   rd_unsupported,
  // fault events
  input  wire logic                              power_stage_fault,
  input  wire logic                              startup_active,
  input  wire logic [tel_pkg::WORD_W-1:0]        vout_mv,
  input  wire logic                              output_reset_fault,
  input  wire logic                              output_floor_fault,
  input  wire logic                              missing_phase_pulse_fault,
  // measurement samples
  input  wire logic                              meas_valid,
  input  wire logic [tel_pkg::SLOT_W-1:0]        meas_slot,
  input  wire logic signed [tel_pkg::WORD_W-1:0] meas_value,
  input  wire logic signed [tel_pkg::EXP_W-1:0]  meas_exp,
  input  wire logic                              vid_valid,
  input  wire logic [tel_pkg::WORD_W-1:0]        output_voltage_vid_code
);
  import tel_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        status;
    logic [WORD_W-1:0] vid;
    logic              pend;
    logic [CODE_W-1:0] pend_code;
    logic              ans_valid;
    logic [CODE_W-1:0] ans_code;
    logic [WORD_W-1:0] ans_data;
    logic              ans_bad;
  } regs_s;

  typedef enum {
    K_STATUS,
    K_LINEAR,
    K_VID,
    K_NONE
  } kind_e;

  regs_s r;
  regs_s n;

  tel_mem_if mif ();

  logic              enc_valid;
  logic [SLOT_W-1:0] enc_slot;
  logic [WORD_W-1:0] enc_word;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic kind_e cmd_kind(input logic [CODE_W-1:0] c);
    kind_e k;
    unique case (c)
      CMD_VENDOR_STATUS: k = K_STATUS;
      CMD_VIN,
      CMD_IIN,
      CMD_IOUT,
      CMD_TEMP,
      CMD_VOUT_LINEAR:   k = K_LINEAR;
      CMD_VOUT_VID:      k = K_VID;
      default:           k = K_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [SLOT_W-1:0] cmd_slot(input logic [CODE_W-1:0] c);
    logic [SLOT_W-1:0] s;
    unique case (c)
      CMD_VIN:         s = SLOT_VIN;
      CMD_IIN:         s = SLOT_IIN;
      CMD_IOUT:        s = SLOT_IOUT;
      CMD_TEMP:        s = SLOT_TEMP;
      CMD_VOUT_LINEAR: s = SLOT_VOUT;
      default:         s = SLOT_VIN;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // linear conversion and word store
  // ----------------------------------------------------------------
  lin_encoder u_enc (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (meas_valid),
    .in_slot   (meas_slot),
    .in_value  (meas_value),
    .in_exp    (meas_exp),
    .out_valid (enc_valid),
    .out_slot  (enc_slot),
    .out_word  (enc_word)
  );

  tel_mem u_mem (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .mif     (mif.store)
  );

  assign mif.we    = enc_valid;
  assign mif.waddr = enc_slot;
  assign mif.wdata = enc_word;
  assign mif.re    = cmd_valid;
  assign mif.raddr = cmd_slot(cmd_code);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n           = r;
    n.ans_valid = 1'b0;

    // clear first so an event in the same cycle still lands
    if (clear_faults)
      n.status = STS_RESET;
    if (power_stage_fault)
      n.status[STS_PS_BIT] = 1'b1;
    if (startup_active && vout_mv > PREBIAS_MV)
      n.status[STS_PB_BIT] = 1'b1;
    if (output_reset_fault)
      n.status[STS_RST_BIT] = 1'b1;
    if (output_floor_fault)
      n.status[STS_FLOOR_BIT] = 1'b1;
    if (missing_phase_pulse_fault)
      n.status[STS_PHASE_BIT] = 1'b1;
    n.status[STS_CS_HI:STS_CS_LO] = '0;

    if (vid_valid)
      n.vid = output_voltage_vid_code;

    // stage 1 waits for the store's registered read data
    n.pend      = cmd_valid;
    n.pend_code = cmd_code;

    if (r.pend)
    begin
      n.ans_valid = 1'b1;
      n.ans_code  = r.pend_code;
      n.ans_bad   = 1'b0;
      unique case (cmd_kind(r.pend_code))
        K_STATUS: n.ans_data = {{(WORD_W-8){1'b0}}, r.status};
        K_LINEAR: n.ans_data = mif.rdata;
        K_VID:    n.ans_data = r.vid;
        K_NONE:
        begin
          n.ans_data = '0;
          n.ans_bad  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '0;
    else if (ce)
      r <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_valid       = r.ans_valid;
  assign rd_code        = r.ans_code;
  assign rd_data        = r.ans_data;
  assign rd_unsupported = r.ans_bad;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cmd_taken;
    ce && cmd_valid;
  endsequence

  sequence s_two_enabled;
    s_cmd_taken ##1 ce;
  endsequence

  sequence s_status_req;
    ce && cmd_valid && cmd_code == CMD_VENDOR_STATUS;
  endsequence

  sequence s_pb_cause;
    ce && startup_active && vout_mv > PREBIAS_MV;
  endsequence

  // a clear with no event beside it, so the whole byte must come back empty
  sequence s_clear_alone;
    ce && clear_faults && !startup_active && !power_stage_fault && !output_reset_fault
      && !output_floor_fault && !missing_phase_pulse_fault;
  endsequence

  a_ps_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && power_stage_fault |=> r.status[STS_PS_BIT])
    else $error("power stage fault not latched");

  a_pb_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(r.status[STS_PB_BIT]) |-> $past(startup_active && vout_mv > PREBIAS_MV))
    else $error("pre-bias flag set without cause");

  a_cs_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_valid && rd_code == CMD_VENDOR_STATUS |-> rd_data[WORD_W-1:STS_PS_BIT+1] == '0
      && rd_data[STS_CS_HI:STS_CS_LO] == '0)
    else $error("status byte reserved bits not zero");

  a_rst_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && output_reset_fault |=> r.status[STS_RST_BIT])
    else $error("output reset fault not latched");

  a_floor_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && output_floor_fault |=> r.status[STS_FLOOR_BIT])
    else $error("output floor fault not latched");

  a_phase_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && missing_phase_pulse_fault |=> r.status[STS_PHASE_BIT])
    else $error("phase fault not latched");

  a_answer_time: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_two_enabled |=> rd_valid && rd_code == $past(cmd_code, 2))
    else $error("answer not two enabled cycles after command");

  a_vid_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_valid && rd_code == CMD_VOUT_VID |-> rd_data == $past(r.vid) && !rd_unsupported)
    else $error("vid readback does not match stored code");

  a_flag_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.status[STS_PS_BIT] && !clear_faults |=> r.status[STS_PS_BIT])
    else $error("latched flag dropped without clear");

  a_pb_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_pb_cause |=> r.status[STS_PB_BIT])
    else $error("pre-bias fault not latched");

  a_status_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_status_req ##1 ce |=> rd_valid && !rd_unsupported
      && rd_data == WORD_W'($past(r.status)))
    else $error("status read does not return the status byte");

  a_clear_status: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_clear_alone |=> r.status == STS_RESET)
    else $error("clear did not empty the status byte");

  // the event must win, or a fault arriving during a clear would be lost
  a_clear_loses: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && clear_faults && missing_phase_pulse_fault |=> r.status[STS_PHASE_BIT])
    else $error("event lost to a clear in the same cycle");

  a_frozen_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ce |=> $stable(r.status) && $stable(rd_data))
    else $error("state moved while the clock enable was low");

  a_answer_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && !r.pend |=> !rd_valid)
    else $error("answer strobe longer than one enabled cycle");

  a_unknown_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_valid && rd_unsupported |-> rd_data == '0)
    else $error("unsupported answer carries data");

  a_vid_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && vid_valid |=> r.vid == $past(output_voltage_vid_code))
    else $error("vid code not stored");

endmodule // tel_status_regs
